// ### ccsr_host.sv
// host-side model that issues single-byte register requests to the bank
`timescale 1ns/1ps
module ccsr_host (
	output ccsr_pkg::ccsr_req_t      req,
	input  wire logic                clk,
	input  wire ccsr_pkg::ccsr_rsp_t rsp
);
	import ccsr_pkg::*;

	initial begin
		req = '0;
	end

	// ------------------------------------------------------------
	// one byte per call, answer taken one cycle after the request
	// ------------------------------------------------------------
	// released address and data lines show the inverse of their last value
	task automatic xfer(input logic wr, input logic [6:0] target, input logic [7:0] addr,
		input logic [7:0] wdata, output logic ack, output logic nack, output logic [7:0] rdata);
		@(posedge clk);
		req.wr     <= wr;
		req.rd     <= ~wr;
		req.target <= target;
		req.addr   <= addr;
		req.wdata  <= wdata;
		@(posedge clk);
		req.wr    <= 1'b0;
		req.rd    <= 1'b0;
		req.addr  <= ~addr;
		req.wdata <= ~wdata;
		#1;
		ack   = rsp.ack;
		nack  = rsp.nack;
		rdata = rsp.rdata;
	endtask
endmodule

// ### ccsr_pkg.sv
// constants and carrier types for the charger control and status register bank
package ccsr_pkg;

	// ------------------------------------------------------------
	// bus target and register offsets
	// ------------------------------------------------------------
	localparam logic [6:0] CCSR_TARGET_ADDR = 7'h69;
	localparam logic [7:0] CCSR_OFS_VOLT    = 8'h02;
	localparam logic [7:0] CCSR_OFS_CUR     = 8'h03;
	localparam logic [7:0] CCSR_OFS_SET1    = 8'h04;
	localparam logic [7:0] CCSR_OFS_SET2    = 8'h05;
	localparam logic [7:0] CCSR_OFS_TEMP    = 8'h06;
	localparam logic [7:0] CCSR_OFS_LOOP    = 8'h07;
	localparam logic [7:0] CCSR_OFS_FAULT   = 8'h08;
	localparam logic [7:0] CCSR_OFS_FLAGS   = 8'h09;
	localparam logic [7:0] CCSR_OFS_MASK    = 8'h0a;

	// ------------------------------------------------------------
	// reset values and writable-bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] CCSR_RST_VOLT  = 8'h01;
	localparam logic [7:0] CCSR_RST_CUR   = 8'h4a;
	localparam logic [7:0] CCSR_RST_SET1  = 8'h0a;
	localparam logic [7:0] CCSR_RST_SET2  = 8'h54;
	localparam logic [7:0] CCSR_RST_TEMP  = 8'h97;
	localparam logic [7:0] CCSR_RST_MASK  = 8'h00;
	localparam logic [7:0] CCSR_WMASK_VOLT = 8'h0f;
	localparam logic [7:0] CCSR_WMASK_CUR  = 8'h7f;
	localparam logic [7:0] CCSR_WMASK_SET1 = 8'h3f;
	localparam logic [7:0] CCSR_WMASK_FULL = 8'hff;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CCSR_POS_CELL      = 3;
	localparam int CCSR_POS_IN_LIMIT  = 4;
	localparam int CCSR_POS_DRIVE     = 5;
	localparam int CCSR_POS_RATE      = 3;
	localparam int CCSR_POS_TRK_TMO   = 6;
	localparam int CCSR_POS_FAST_TMO  = 4;
	localparam int CCSR_POS_TERM      = 2;
	localparam int CCSR_POS_LOW_THR   = 6;
	localparam int CCSR_POS_HIGH_THR  = 4;
	localparam int CCSR_POS_VCUT      = 2;
	localparam int CCSR_LATCH_BITS    = 6;

	// ------------------------------------------------------------
	// alert pulse timing
	// ------------------------------------------------------------
	localparam int CCSR_CLK_PERIOD_PS = 4000;
	localparam int CCSR_ALERT_US      = 456;
	localparam int CCSR_ALERT_CYCLES  = (CCSR_ALERT_US * 1000000) / CCSR_CLK_PERIOD_PS;
	localparam int CCSR_CNT_W         = 18;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] target;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccsr_req_t;

	typedef struct packed {
		logic       ack;
		logic       nack;
		logic [7:0] rdata;
	} ccsr_rsp_t;

	typedef struct packed {
		logic       two_cells;
		logic [2:0] charge_voltage_code;
		logic [2:0] input_current_limit;
		logic [3:0] charge_current_code;
		logic       gate_drive_strength;
		logic [1:0] switching_rate_select;
		logic [2:0] input_voltage_regulation;
		logic [1:0] trickle_phase_timeout;
		logic [1:0] fast_charge_timeout;
		logic [1:0] termination_current;
		logic [1:0] trickle_current;
		logic [1:0] low_caution_threshold;
		logic [1:0] high_caution_threshold;
		logic [1:0] high_caution_voltage_cut;
		logic [1:0] low_caution_current_fraction;
	} ccsr_cfg_t;

endpackage

// ### ccsr_regs.sv
// charger control, status, read-to-clear flag and alert mask register bank
`timescale 1ns/1ps
// Notes on behaviour
// [R01] voltage register bit 3 picks one cell (0, default) or two cells (1).
// [R02] voltage bits 2..0 pick per-cell target 4.1V..4.5V, default code 001.
// [R03] current register bits 6..4 pick input limit 90mA..2800mA, default 100.
// [R04] current bits 3..0: 0000 stops charging, else 200mA steps, default 1010.
// [R05] setting one bit 5 picks gate drive: 0 fast (default), 1 slow.
// [R06] setting one bits 4..3 pick switching rate 400..1000kHz, default 01.
// [R07] setting one bits 2..0 pick input voltage regulation point, default 010.
// [R08] setting two bits 7..6 pick trickle timeout 15..60 minutes, default 01.
// [R09] setting two bits 5..4 pick fast charge timeout 4..10 hours, default 6h.
// [R10] setting two bits 3..2 pick termination current 100..400mA, default 01.
// [R11] setting two bits 1..0 pick trickle current 200..500mA.
// [R12] temperature bits 7..6 pick low caution threshold, default 10.
// [R13] temperature bits 5..4 pick high caution threshold, default 01.
// [R14] temperature bits 3..2 pick high caution voltage cut, default 100mV.
// [R15] temperature bits 1..0 pick low caution current fraction, default 11.
// [R16] loop status bits 7..3 show which regulation loop is in control.
// [R17] loop status bits 2..0 show overcurrent, low and high caution zone.
// [R18] fault status bit 6 is high while input is above 14V.
// [R19] fault status bit 5 is high while battery exceeds 104 percent target.
// [R20] fault status bits 4..0 show timer, done, shutdown, cold, hot.
// [R21] flag bits 5..0 latch on status rise and clear when flags are read.
// [R22] flag bits 7..6 follow status until read; zero after read or status low.
// [R23] a set mask bit withholds the alert for that event; default clear.
// [R24] masked events still update status and flag bits.
// [R25] an unmasked rising event gives one low alert pulse of 456us.
// [R26] the bank answers only to bus target address 0x69.
// [R27] reserved bits read zero and ignore writes.
module ccsr_regs #(
	parameter int ALERT_CYCLES = ccsr_pkg::CCSR_ALERT_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire ccsr_pkg::ccsr_req_t req,
	output ccsr_pkg::ccsr_rsp_t      rsp,
	input  wire logic [7:0]         loop_in,
	input  wire logic [7:0]         fault_in,
	output ccsr_pkg::ccsr_cfg_t      cfg,
	output logic                    alert_n
);
	import ccsr_pkg::*;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]            volt_reg;
	logic [7:0]            cur_reg;
	logic [7:0]            set1_reg;
	logic [7:0]            set2_reg;
	logic [7:0]            temp_reg;
	logic [7:0]            mask_reg;
	logic [7:0]            loop_s1, loop_s2, loop_s3, loop_stat;
	logic [7:0]            fault_s1, fault_s2, fault_s3, fault_stat;
	logic [7:0]            fault_prev;
	logic [CCSR_LATCH_BITS-1:0] flag_lat;
	logic [1:0]            seen;
	logic [CCSR_CNT_W-1:0] alert_cnt;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire        sel      = req.target == CCSR_TARGET_ADDR;  // [R26]
	wire        do_wr    = sel && req.wr;
	wire        do_rd    = sel && req.rd;
	wire        hit_volt = req.addr == CCSR_OFS_VOLT;
	wire        hit_cur  = req.addr == CCSR_OFS_CUR;
	wire        hit_set1 = req.addr == CCSR_OFS_SET1;
	wire        hit_set2 = req.addr == CCSR_OFS_SET2;
	wire        hit_temp = req.addr == CCSR_OFS_TEMP;
	wire        hit_mask = req.addr == CCSR_OFS_MASK;
	wire        hit_flag = req.addr == CCSR_OFS_FLAGS;
	wire        mapped   = hit_volt | hit_cur | hit_set1 | hit_set2 | hit_temp | hit_mask | hit_flag
	                       | req.addr == CCSR_OFS_LOOP | req.addr == CCSR_OFS_FAULT;
	wire        rd_flags = do_rd && hit_flag;
	wire [7:0]  rise     = fault_stat & ~fault_prev;
	wire [7:0]  flags    = {fault_stat[7:6] & ~seen, flag_lat};  // [R22]
	wire        event_go = |(rise & ~mask_reg);  // [R23]

	wire [7:0] rd_mux =
		hit_volt ? volt_reg :
		hit_cur  ? cur_reg :
		hit_set1 ? set1_reg :
		hit_set2 ? set2_reg :
		hit_temp ? temp_reg :
		hit_mask ? mask_reg :
		hit_flag ? flags :
		req.addr == CCSR_OFS_LOOP ? loop_stat :  // [R16] [R17]
		req.addr == CCSR_OFS_FAULT ? fault_stat :  // [R18] [R19] [R20]
		8'h00;

	// masked write: reserved bits keep zero
	function automatic logic [7:0] wmerge(input logic [7:0] wmask, input logic [7:0] d);
		return d & wmask;
	endfunction

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			volt_reg <= CCSR_RST_VOLT;  // [R01] [R02]
			cur_reg  <= CCSR_RST_CUR;   // [R03] [R04]
			set1_reg <= CCSR_RST_SET1;  // [R05] [R06] [R07]
			set2_reg <= CCSR_RST_SET2;  // [R08] [R09] [R10] [R11]
			temp_reg <= CCSR_RST_TEMP;  // [R12] [R13] [R14] [R15]
			mask_reg <= CCSR_RST_MASK;
		end else if (do_wr) begin
			if (hit_volt) volt_reg <= wmerge(CCSR_WMASK_VOLT, req.wdata);  // [R27]
			if (hit_cur)  cur_reg  <= wmerge(CCSR_WMASK_CUR, req.wdata);   // [R27]
			if (hit_set1) set1_reg <= wmerge(CCSR_WMASK_SET1, req.wdata);  // [R27]
			if (hit_set2) set2_reg <= wmerge(CCSR_WMASK_FULL, req.wdata);
			if (hit_temp) temp_reg <= wmerge(CCSR_WMASK_FULL, req.wdata);
			if (hit_mask) mask_reg <= wmerge(CCSR_WMASK_FULL, req.wdata);
		end
	end

	// ------------------------------------------------------------
	// configuration outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= '0;
		end else begin
			cfg.two_cells                    <= volt_reg[CCSR_POS_CELL];  // [R01]
			cfg.charge_voltage_code          <= volt_reg[2:0];  // [R02]
			cfg.input_current_limit          <= cur_reg[CCSR_POS_IN_LIMIT +: 3];  // [R03]
			cfg.charge_current_code          <= cur_reg[3:0];  // [R04]
			cfg.gate_drive_strength          <= set1_reg[CCSR_POS_DRIVE];  // [R05]
			cfg.switching_rate_select        <= set1_reg[CCSR_POS_RATE +: 2];  // [R06]
			cfg.input_voltage_regulation     <= set1_reg[2:0];  // [R07]
			cfg.trickle_phase_timeout        <= set2_reg[CCSR_POS_TRK_TMO +: 2];  // [R08]
			cfg.fast_charge_timeout          <= set2_reg[CCSR_POS_FAST_TMO +: 2];  // [R09]
			cfg.termination_current          <= set2_reg[CCSR_POS_TERM +: 2];  // [R10]
			cfg.trickle_current              <= set2_reg[1:0];  // [R11]
			cfg.low_caution_threshold        <= temp_reg[CCSR_POS_LOW_THR +: 2];  // [R12]
			cfg.high_caution_threshold       <= temp_reg[CCSR_POS_HIGH_THR +: 2];  // [R13]
			cfg.high_caution_voltage_cut     <= temp_reg[CCSR_POS_VCUT +: 2];  // [R14]
			cfg.low_caution_current_fraction <= temp_reg[1:0];  // [R15]
		end
	end

	// ------------------------------------------------------------
	// status input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loop_s1    <= 8'h00;
			loop_s2    <= 8'h00;
			loop_s3    <= 8'h00;
			loop_stat  <= 8'h00;
			fault_s1   <= 8'h00;
			fault_s2   <= 8'h00;
			fault_s3   <= 8'h00;
			fault_stat <= 8'h00;
			fault_prev <= 8'h00;
		end else begin
			loop_s1    <= loop_in;
			loop_s2    <= loop_s1;
			loop_s3    <= loop_s2;
			loop_stat  <= (~(loop_s2 ^ loop_s3) & loop_s3) | ((loop_s2 ^ loop_s3) & loop_stat);
			fault_s1   <= fault_in;
			fault_s2   <= fault_s1;
			fault_s3   <= fault_s2;
			fault_stat <= (~(fault_s2 ^ fault_s3) & fault_s3) | ((fault_s2 ^ fault_s3) & fault_stat);  // [R24]
			fault_prev <= fault_stat;
		end
	end

	// ------------------------------------------------------------
	// flags: a rise in the read cycle survives the clear
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_lat <= '0;
			seen     <= 2'h0;
		end else begin
			flag_lat <= (flag_lat & ~{CCSR_LATCH_BITS{rd_flags}}) | rise[CCSR_LATCH_BITS-1:0];  // [R21] [R24]
			seen     <= (seen | {2{rd_flags}}) & fault_stat[7:6];  // [R22]
		end
	end

	// ------------------------------------------------------------
	// bus answer: one cycle after the request
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp <= '0;
		end else begin
			rsp.ack   <= (do_wr | do_rd) & mapped;  // [R26]
			rsp.nack  <= (do_wr | do_rd) & ~mapped;
			rsp.rdata <= do_rd ? rd_mux : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// alert pulse; events during a pulse do not restart it
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alert_cnt <= '0;
			alert_n   <= 1'b1;
		end else if (alert_cnt == '0) begin
			if (event_go) begin
				alert_cnt <= CCSR_CNT_W'(ALERT_CYCLES);  // [R25]
				alert_n   <= 1'b0;
			end
		end else begin
			alert_cnt <= alert_cnt - 1'b1;
			alert_n   <= alert_cnt == CCSR_CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	int unsigned low_len;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) low_len <= 0;
		else low_len <= alert_n ? 0 : low_len + 1;
	end

	flag_latch_a: assert property (rise[0] |=> flag_lat[0]) else $error("flag missed rise");  // [R21]
	flag_clear_a: assert property (rd_flags && !rise[3] && flag_lat[3] |=> !flag_lat[3])  // [R21]
		else $error("flag kept after read");
	flag_follow_a: assert property (!fault_stat[7] |-> !flags[7]) else $error("flag high without status");  // [R22]
	alert_start_a: assert property (alert_n && event_go |=> !alert_n) else $error("alert not started");  // [R25]
	alert_len_a: assert property (!alert_n |-> low_len < ALERT_CYCLES) else $error("alert too long");  // [R25]
	alert_full_a: assert property ($rose(alert_n) |-> $past(low_len) == ALERT_CYCLES - 1)  // [R25]
		else $error("alert wrong length");
	mask_hold_a: assert property (alert_n && alert_cnt == '0 && !event_go |=> alert_n)  // [R23]
		else $error("masked event alerted");
	masked_flag_a: assert property (rise[2] && mask_reg[2] |=> flag_lat[2]) else $error("masked flag lost");  // [R24]
	foreign_a: assert property (req.target != CCSR_TARGET_ADDR |=> !rsp.ack && !rsp.nack)  // [R26]
		else $error("answered foreign target");
	reserved_a: assert property (do_wr && hit_cur |=> !cur_reg[7]) else $error("reserved bit stored");  // [R27]
	cell_out_a: assert property (do_wr && hit_volt |-> ##2 cfg.two_cells == $past(req.wdata[3], 2))  // [R01]
		else $error("cell count not applied");

	// ------------------------------------------------------------
	// checks: configuration fields follow their registers
	// ------------------------------------------------------------
	cell_map_a: assert property (!$past(rst) |->  // [R01]
		cfg.two_cells == $past(volt_reg[CCSR_POS_CELL])) else $error("cell field wrong");
	vcode_map_a: assert property (!$past(rst) |->  // [R02]
		cfg.charge_voltage_code == $past(volt_reg[2:0])) else $error("voltage code field wrong");
	in_limit_map_a: assert property (!$past(rst) |->  // [R03]
		cfg.input_current_limit == $past(cur_reg[CCSR_POS_IN_LIMIT +: 3])) else $error("input limit field wrong");
	chg_cur_map_a: assert property (!$past(rst) |->  // [R04]
		cfg.charge_current_code == $past(cur_reg[3:0])) else $error("charge current field wrong");
	drive_map_a: assert property (!$past(rst) |->  // [R05]
		cfg.gate_drive_strength == $past(set1_reg[CCSR_POS_DRIVE])) else $error("drive field wrong");
	rate_map_a: assert property (!$past(rst) |->  // [R06]
		cfg.switching_rate_select == $past(set1_reg[CCSR_POS_RATE +: 2])) else $error("rate field wrong");
	vin_reg_map_a: assert property (!$past(rst) |->  // [R07]
		cfg.input_voltage_regulation == $past(set1_reg[2:0])) else $error("input regulation field wrong");
	trk_tmo_map_a: assert property (!$past(rst) |->  // [R08]
		cfg.trickle_phase_timeout == $past(set2_reg[CCSR_POS_TRK_TMO +: 2])) else $error("trickle timeout wrong");
	fast_tmo_map_a: assert property (!$past(rst) |->  // [R09]
		cfg.fast_charge_timeout == $past(set2_reg[CCSR_POS_FAST_TMO +: 2])) else $error("fast timeout wrong");
	term_map_a: assert property (!$past(rst) |->  // [R10]
		cfg.termination_current == $past(set2_reg[CCSR_POS_TERM +: 2])) else $error("termination field wrong");
	trickle_current_map_a: assert property (!$past(rst) |->  // [R11]
		cfg.trickle_current == $past(set2_reg[1:0])) else $error("trickle current field wrong");
	low_thr_map_a: assert property (!$past(rst) |->  // [R12]
		cfg.low_caution_threshold == $past(temp_reg[CCSR_POS_LOW_THR +: 2])) else $error("low threshold wrong");
	high_thr_map_a: assert property (!$past(rst) |->  // [R13]
		cfg.high_caution_threshold == $past(temp_reg[CCSR_POS_HIGH_THR +: 2])) else $error("high threshold wrong");
	vcut_map_a: assert property (!$past(rst) |->  // [R14]
		cfg.high_caution_voltage_cut == $past(temp_reg[CCSR_POS_VCUT +: 2])) else $error("voltage cut wrong");
	frac_map_a: assert property (!$past(rst) |->  // [R15]
		cfg.low_caution_current_fraction == $past(temp_reg[1:0])) else $error("current fraction wrong");

	// ------------------------------------------------------------
	// checks: register writes land and otherwise hold
	// ------------------------------------------------------------
	volt_write_a: assert property (do_wr && hit_volt |=>  // [R27]
		volt_reg == ($past(req.wdata) & CCSR_WMASK_VOLT)) else $error("voltage write lost");
	cur_write_a: assert property (do_wr && hit_cur |=>  // [R27]
		cur_reg == ($past(req.wdata) & CCSR_WMASK_CUR)) else $error("current write lost");
	set1_write_a: assert property (do_wr && hit_set1 |=>  // [R27]
		set1_reg == ($past(req.wdata) & CCSR_WMASK_SET1)) else $error("setting one write lost");
	set2_write_a: assert property (do_wr && hit_set2 |=> set2_reg == $past(req.wdata))  // [R08]
		else $error("setting two write lost");
	temp_write_a: assert property (do_wr && hit_temp |=> temp_reg == $past(req.wdata))  // [R12]
		else $error("temperature write lost");
	mask_write_a: assert property (do_wr && hit_mask |=> mask_reg == $past(req.wdata))  // [R23]
		else $error("mask write lost");
	volt_keep_a: assert property (!(do_wr && hit_volt) |=> $stable(volt_reg))  // [R01]
		else $error("voltage register changed");
	cur_keep_a: assert property (!(do_wr && hit_cur) |=> $stable(cur_reg))  // [R03]
		else $error("current register changed");
	set1_keep_a: assert property (!(do_wr && hit_set1) |=> $stable(set1_reg))  // [R05]
		else $error("setting one changed");
	set2_keep_a: assert property (!(do_wr && hit_set2) |=> $stable(set2_reg))  // [R08]
		else $error("setting two changed");
	temp_keep_a: assert property (!(do_wr && hit_temp) |=> $stable(temp_reg))  // [R12]
		else $error("temperature register changed");
	mask_keep_a: assert property (!(do_wr && hit_mask) |=> $stable(mask_reg))  // [R23]
		else $error("mask register changed");

	// ------------------------------------------------------------
	// checks: bus answers and read data
	// ------------------------------------------------------------
	answer_ok_a: assert property (do_rd && mapped |=> rsp.ack && !rsp.nack)  // [R26]
		else $error("mapped read not acked");
	answer_nack_a: assert property ((do_wr || do_rd) && !mapped |=> rsp.nack && !rsp.ack)  // [R26]
		else $error("unmapped request not refused");
	answer_excl_a: assert property (!(rsp.ack && rsp.nack)) else $error("ack and nack together");  // [R26]
	rdata_idle_a: assert property (!do_rd |=> rsp.rdata == 8'h00)  // [R26]
		else $error("read data without read");
	volt_rsvd_a: assert property (do_rd && hit_volt |=> rsp.rdata[7:4] == 4'h0)  // [R27]
		else $error("voltage reserved bits read high");
	cur_rsvd_a: assert property (do_rd && hit_cur |=> !rsp.rdata[7])  // [R27]
		else $error("current reserved bit read high");
	set1_rsvd_a: assert property (do_rd && hit_set1 |=> rsp.rdata[7:6] == 2'h0)  // [R27]
		else $error("setting one reserved bits read high");
	loop_read_a: assert property (do_rd && req.addr == CCSR_OFS_LOOP |=> rsp.rdata == $past(loop_stat))  // [R16]
		else $error("loop status read wrong");
	fault_read_a: assert property (do_rd && req.addr == CCSR_OFS_FAULT |=> rsp.rdata == $past(fault_stat))  // [R18]
		else $error("fault status read wrong");
	ovp_read_a: assert property (do_rd && hit_flag && !fault_stat[6] |=> !rsp.rdata[6])  // [R22]
		else $error("overvoltage flag read without status");
	mask_read_a: assert property (do_rd && hit_mask |=> rsp.rdata == $past(mask_reg))  // [R23]
		else $error("mask read wrong");

	// ------------------------------------------------------------
	// checks: status capture, flags and alert
	// ------------------------------------------------------------
	loop_sync_a: assert property (loop_s2 == loop_s3 |=> loop_stat == $past(loop_s3))  // [R16]
		else $error("loop status not taken");
	loop_wait_a: assert property (loop_s2 != loop_s3 |=> $stable(loop_stat))  // [R16]
		else $error("loop status taken early");
	fault_sync_a: assert property (fault_s2 == fault_s3 |=> fault_stat == $past(fault_s3))  // [R20]
		else $error("fault status not taken");
	fault_wait_a: assert property (fault_s2 != fault_s3 |=> $stable(fault_stat))  // [R20]
		else $error("fault status taken early");
	prev_track_a: assert property (!$past(rst) |-> fault_prev == $past(fault_stat))  // [R21]
		else $error("previous status lost");
	flag_all_a: assert property (|rise[5:0] |=> (flag_lat & $past(rise[5:0])) == $past(rise[5:0]))  // [R21]
		else $error("flag missed rise");
	flag_empty_a: assert property (rd_flags && rise[5:0] == '0 |=> flag_lat == '0)  // [R21]
		else $error("flags kept after read");
	flag_keep_a: assert property (!rd_flags |=> (flag_lat & $past(flag_lat)) == $past(flag_lat))  // [R21]
		else $error("flag lost without read");
	seen_clear_a: assert property (!fault_stat[7] |=> !seen[1])  // [R22]
		else $error("read mark kept without status");
	flag_show_a: assert property (fault_stat[6] && !seen[1] |-> flags[6])  // [R22]
		else $error("overvoltage flag hidden");
	flag_gone_a: assert property (rd_flags && fault_stat[6] |=> !flags[6])  // [R22]
		else $error("overvoltage flag kept after read");
	alert_idle_a: assert property (alert_cnt == '0 |-> alert_n)  // [R25]
		else $error("alert low while idle");
	alert_once_a: assert property (!alert_n && event_go |=> alert_cnt == $past(alert_cnt) - 1'b1)  // [R25]
		else $error("alert restarted");
	alert_cause_a: assert property ($fell(alert_n) |-> $past(event_go))  // [R23]
		else $error("alert without unmasked event");

	alert_c: cover property ($rose(alert_n));
	two_cell_c: cover property (cfg.two_cells);
	flag_read_c: cover property (rd_flags && flag_lat != '0);
	masked_c: cover property (|(rise & mask_reg));
	nack_c: cover property (rsp.nack);

endmodule

// ### tb.sv
// self-checking testbench for the charger control and status register bank
`timescale 1ns/1ps
module tb;
	import ccsr_pkg::*;
	localparam int AC = 8;
	logic       clk      = 1'b0;
	logic       rst      = 1'b1;
	logic [7:0] loop_in  = 8'h00;
	logic [7:0] fault_in = 8'h00;
	logic       alert_n;
	ccsr_req_t  req;
	ccsr_rsp_t  rsp;
	ccsr_cfg_t  cfg;
	int         error_cnt   = 0;
	int         comparisons = 0;
	logic [7:0] ofs [6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a};
	logic [7:0] wm  [6] = '{8'h0f, 8'h7f, 8'h3f, 8'hff, 8'hff, 8'hff};

	always #2 clk = ~clk;

	ccsr_regs #(.ALERT_CYCLES(AC)) DUT (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .loop_in(loop_in),
		.fault_in(fault_in), .cfg(cfg), .alert_n(alert_n));
	ccsr_host host (.clk(clk), .req(req), .rsp(rsp));

	// ------------------------------------------------------------
	// comparison, bus tasks and alert measurement
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ack, nack;
		logic [7:0] rd_d;
		host.xfer(1'b1, 7'h69, a, d, ack, nack, rd_d);
		check({6'h0, ack, nack}, 8'h02, "write answer");
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic ack, nack;
		logic [7:0] d;
		host.xfer(1'b0, 7'h69, a, 8'h00, ack, nack, d);
		check({6'h0, ack, nack}, 8'h02, "read answer");
		check(d, exp, "read data");
	endtask

	// waits for the alert to fall, then counts the cycles it stays low
	task automatic alert_len(output int n);
		int w;
		n = 0;
		for (w = 0; w < 20 && alert_n === 1'b1; w++) begin
			@(posedge clk);
			#1;
		end
		while (alert_n === 1'b0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(5000 * 4);
		error_cnt++;
		summarize();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		int i;
		int n;
		logic ack, nack;
		logic [7:0] d;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(8'h02, 8'h01);
		rd(8'h03, 8'h4a);
		rd(8'h04, 8'h0a);
		rd(8'h05, 8'h54);
		rd(8'h06, 8'h97);
		rd(8'h0a, 8'h00);
		check({4'h0, cfg.two_cells, cfg.charge_voltage_code}, 8'h01, "cfg voltage");
		for (i = 0; i < 6; i++) begin
			wr(ofs[i], 8'hff);
			rd(ofs[i], wm[i]);
		end
		wr(8'h02, 8'h0d);
		wr(8'h03, 8'h95);
		wr(8'h04, 8'hee);
		wr(8'h05, 8'hb4);
		wr(8'h06, 8'h2a);
		wr(8'h0a, 8'h10);
		@(posedge clk);
		#1;
		check({4'h0, cfg.two_cells, cfg.charge_voltage_code}, 8'h0d, "cfg voltage");
		check({1'b0, cfg.input_current_limit, cfg.charge_current_code}, 8'h15, "cfg current");
		check({2'b0, cfg.gate_drive_strength, cfg.switching_rate_select, cfg.input_voltage_regulation},
			8'h2e, "cfg setting one");
		check({cfg.trickle_phase_timeout, cfg.fast_charge_timeout, cfg.termination_current,
			cfg.trickle_current}, 8'hb4, "cfg setting two");
		check({cfg.low_caution_threshold, cfg.high_caution_threshold, cfg.high_caution_voltage_cut,
			cfg.low_caution_current_fraction}, 8'h2a, "cfg temperature");
		wr(8'h07, 8'h55);
		rd(8'h07, 8'h00);
		host.xfer(1'b0, 7'h69, 8'h0b, 8'h00, ack, nack, d);
		check({6'h0, ack, nack}, 8'h01, "unmapped answer");
		host.xfer(1'b1, 7'h68, 8'h0a, 8'hff, ack, nack, d);
		check({6'h0, ack, nack}, 8'h00, "foreign target answer");
		rd(8'h0a, 8'h10);
		@(posedge clk);
		loop_in  <= 8'ha5;
		fault_in <= 8'h10;
		alert_len(n);
		check(8'(n), 8'h00, "masked alert length");
		rd(8'h07, 8'ha5);
		rd(8'h09, 8'h10);
		rd(8'h09, 8'h00);
		wr(8'h0a, 8'h00);
		@(posedge clk);
		fault_in <= 8'h18;
		alert_len(n);
		check(8'(n), 8'(AC), "alert length");
		rd(8'h09, 8'h08);
		@(posedge clk);
		fault_in <= 8'hf8;
		alert_len(n);
		check(8'(n), 8'(AC), "alert length");
		rd(8'h08, 8'hf8);
		rd(8'h09, 8'he0);
		rd(8'h09, 8'h00);
		summarize();
	end
endmodule
